/* core/css_defs.svh */
// constants of the channel scan sequencer: offsets, fields, resets, timing
// assumes a 20 MHz core clock and a byte-addressed 8-bit APB window
`ifndef CSS_DEFS_SVH
`define CSS_DEFS_SVH
// register byte offsets
`define CSS_OFF_CTRL 8'h00
`define CSS_OFF_REPEAT 8'h04
`define CSS_OFF_LEN 8'h08
`define CSS_OFF_CMD 8'h0C
`define CSS_OFF_STATUS 8'h10
`define CSS_OFF_LIST 8'h80
// control field positions
`define CSS_CTRL_MODE 1:0
`define CSS_CTRL_ROUTE 2
`define CSS_CTRL_SRC 5:3
`define CSS_CTRL_ENDLESS 6
`define CSS_CTRL_TRIGOUT 7
`define CSS_CTRL_MIXED 8
// command bits
`define CSS_CMD_INIT 0
`define CSS_CMD_SHOT 1
// status field positions
`define CSS_ST_STATE 2:0
`define CSS_ST_MEMHELD 3
`define CSS_ST_PTR 12:8
`define CSS_ST_CYCLES 31:16
// reset values
`define CSS_RST_REPEAT 16'h0001
`define CSS_RST_LEN 6'h01
// four-wire partner distance, as an index flip
`define CSS_PAIR_BIT 3
// free-running advance period and clock period
`define CSS_FREE_PERIOD_NS 10000
`define CSS_CLK_PERIOD_NS 50
`define CSS_FREE_CYCLES (`CSS_FREE_PERIOD_NS / `CSS_CLK_PERIOD_NS)
`endif

/* core/css_pkg.sv */
// types of the channel scan sequencer
// assumes css_defs.svh for the numeric constants other than the enum codes set here
package css_pkg;
  // routing mode
  typedef enum logic [1:0] {
    CSS_POTENTIAL_MEASURE = 2'h0,
    CSS_TWO_WIRE_OHMS = 2'h1,
    CSS_FOUR_WIRE_OHMS = 2'h2
  } cssMode_type;
  // advance source
  typedef enum logic [2:0] {
    CSS_HOST_COMMAND = 3'h0,
    CSS_OUTSIDE_EVENT = 3'h1,
    CSS_HOLD = 3'h2,
    CSS_HANDSHAKE_LINE = 3'h3,
    CSS_FREE_RUNNING = 3'h4
  } cssSrc_type;
  // sequencer states
  typedef enum logic [2:0] {
    CSS_IDLE = 3'h0,
    CSS_BREAK = 3'h1,
    CSS_MAKE = 3'h2,
    CSS_DWELL = 3'h3,
    CSS_DONE = 3'h4
  } cssState_type;
  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cssApbReq_type;
  // apb answer of the slave
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cssApbRsp_type;
endpackage

/* core/css_scan_seq.sv */
// channel scan sequencer for one 16-channel solid-state switch card
// assumes an APB master, a synchronous reset, and asynchronous event pins
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "css_defs.svh"
module css_scan_seq
  import css_pkg::*;
#(
  parameter int LIST_DEPTH = 32, // channel list entries
  parameter logic [3:0] CARD_ID = 4'h1 // this card's number, arbitrary
) (
  input wire logic clk, // 20 MHz core clock
  input wire logic reset, // synchronous, active high
  input wire cssApbReq_type apbReq, // apb request
  output cssApbRsp_type apbRsp, // apb answer, registered
  input wire logic outsideEvent, // async outside event pin
  input wire logic meterDone, // async handshake from the meter
  output logic [15:0] chanClose, // per-channel switch drive
  output logic [1:0] treeIsoClose, // tree isolation A (bit0), B (bit1)
  output logic bankSplit, // bank 0 / bank 1 separated
  output logic closedPulse, // handshake: channel closed
  output logic trigOut // trigger pulse to the meter
);
  //////////////////////////////////////////////////////////////////////////
  localparam int PW = $clog2(LIST_DEPTH); // pointer width

  // module state apart from the list memories in one record
  typedef struct packed {
    cssState_type st; // sequencer state
    logic [PW-1:0] ptr; // list pointer
    logic [15:0] cycles; // cycles left
    logic [15:0] mask; // closed channels
    logic [1:0] tree; // tree isolation drive
    logic split; // bank split drive
    logic cpulse; // closed pulse
    logic tpulse; // trigger out pulse
    logic [7:0] timer; // free-running countdown
    logic memHeld; // running from local copy
    logic [8:0] ctrl; // control register
    logic [15:0] repeatCnt; // repeat count register
    logic [5:0] len; // list length register
    logic [2:0] evSync; // outside event synchroniser
    logic [2:0] hsSync; // handshake synchroniser
    logic evLvl; // accepted event level
    logic hsLvl; // accepted handshake level
    cssApbRsp_type rsp; // apb answer
  } cssRegs_type;

  cssRegs_type s_q; // registered state
  cssRegs_type s_d; // next state
  logic [7:0] stageMem [LIST_DEPTH]; // list as written by software
  logic [7:0] localMem [LIST_DEPTH]; // on-module copy for fast scans

  //////////////////////////////////////////////////////////////////////////
  // address decode, used for the error answer; the read mux decodes the address itself
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `CSS_OFF_CTRL) || (a == `CSS_OFF_REPEAT) ||
      (a == `CSS_OFF_LEN) || (a == `CSS_OFF_CMD) ||
      (a == `CSS_OFF_STATUS) || (a >= `CSS_OFF_LIST);
  endfunction

  // channel mask of one list entry {card, channel} for this card
  function automatic logic [15:0] entryMask(input logic [7:0] e,
                                            input logic four);
    logic [3:0] ch;
    entryMask = 16'h0000;
    ch = e[3:0];
    if (e[7:4] == CARD_ID) begin
      entryMask[ch] = 1'b1;
      if (four) begin
        entryMask[ch ^ 4'(1 << `CSS_PAIR_BIT)] = 1'b1;
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // decoded controls
  cssMode_type mode;
  cssSrc_type src;
  logic wrEdge; // write takes effect now
  logic cmdWr; // write to the command register
  logic initiate; // start request
  logic shot; // one-shot advance
  logic modeChange; // control write changes the routing mode
  logic downloadable; // list goes to local memory
  logic advance; // advance event this cycle
  logic lastEntry; // pointer on last entry
  logic evRise; // outside event edge
  logic hsRise; // handshake edge
  logic [7:0] curEntry; // entry under the pointer
  logic [PW-1:0] lastPtr; // index of last entry

  assign mode = cssMode_type'(s_q.ctrl[`CSS_CTRL_MODE]);
  assign src = cssSrc_type'(s_q.ctrl[`CSS_CTRL_SRC]);
  assign wrEdge = apbReq.psel & apbReq.penable & s_q.rsp.pready & apbReq.pwrite;
  assign cmdWr = wrEdge & (apbReq.paddr == `CSS_OFF_CMD);
  assign initiate = cmdWr & apbReq.pwdata[`CSS_CMD_INIT];
  assign shot = cmdWr & apbReq.pwdata[`CSS_CMD_SHOT];
  // a spent four-wire scan keeps two channels closed; leaving four-wire must not
  assign modeChange = wrEdge & (apbReq.paddr == `CSS_OFF_CTRL) &
    (apbReq.pwdata[`CSS_CTRL_MODE] != s_q.ctrl[`CSS_CTRL_MODE]);
  assign downloadable = ((src == CSS_HANDSHAKE_LINE) || (src == CSS_FREE_RUNNING)) &
    ~s_q.ctrl[`CSS_CTRL_MIXED];
  assign lastPtr = PW'(s_q.len - 6'h01);
  assign lastEntry = (s_q.ptr == lastPtr);
  assign curEntry = s_q.memHeld ? localMem[s_q.ptr] : stageMem[s_q.ptr];
  // second and third stage agree on a new level
  assign evRise = s_q.evSync[1] & s_q.evSync[2] & ~s_q.evLvl;
  assign hsRise = s_q.hsSync[1] & s_q.hsSync[2] & ~s_q.hsLvl;

  // advance source selection
  always_comb begin
    advance = 1'b0;
    if (s_q.st == CSS_DWELL) begin
      unique case (src)
        CSS_HOST_COMMAND, CSS_HOLD: advance = shot;
        CSS_OUTSIDE_EVENT: advance = evRise;
        CSS_HANDSHAKE_LINE: advance = hsRise;
        CSS_FREE_RUNNING: advance = (s_q.timer == 8'h00);
        default: advance = shot; // illegal codes act as hold
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // list storage; written at the apb completion edge
  always_ff @(posedge clk) begin
    if (wrEdge && apbReq.paddr >= `CSS_OFF_LIST) begin
      stageMem[PW'(apbReq.paddr[7:2])] <= apbReq.pwdata[7:0];
    end
  end

  // on-module copy taken at initiate of a downloadable list; every card copies it whole
  always_ff @(posedge clk) begin
    if (initiate && downloadable) begin
      for (int i = 0; i < LIST_DEPTH; i++) begin
        localMem[i] <= stageMem[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // next-state logic: bus slave, synchronisers, sequencer
  always_comb begin
    s_d = s_q;
    s_d.cpulse = 1'b0;
    s_d.tpulse = 1'b0;
    // synchronisers; stage 0 feeds only stage 1
    s_d.evSync = {s_q.evSync[1:0], outsideEvent};
    s_d.hsSync = {s_q.hsSync[1:0], meterDone};
    if (s_q.evSync[1] == s_q.evSync[2]) begin
      s_d.evLvl = s_q.evSync[2];
    end
    if (s_q.hsSync[1] == s_q.hsSync[2]) begin
      s_d.hsLvl = s_q.hsSync[2];
    end
    // apb: one wait state, answer in second access cycle
    s_d.rsp.pready = apbReq.psel & apbReq.penable & ~s_q.rsp.pready;
    s_d.rsp.pslverr = s_d.rsp.pready & ~isMapped(apbReq.paddr);
    s_d.rsp.prdata = 32'h0000_0000;
    if (s_d.rsp.pready && !apbReq.pwrite) begin
      unique case (1'b1)
        apbReq.paddr == `CSS_OFF_CTRL: s_d.rsp.prdata[8:0] = s_q.ctrl;
        apbReq.paddr == `CSS_OFF_REPEAT: s_d.rsp.prdata[15:0] = s_q.repeatCnt;
        apbReq.paddr == `CSS_OFF_LEN: s_d.rsp.prdata[5:0] = s_q.len;
        apbReq.paddr == `CSS_OFF_STATUS: begin
          s_d.rsp.prdata[`CSS_ST_STATE] = s_q.st;
          s_d.rsp.prdata[`CSS_ST_MEMHELD] = s_q.memHeld;
          s_d.rsp.prdata[`CSS_ST_PTR] = 5'(s_q.ptr);
          s_d.rsp.prdata[`CSS_ST_CYCLES] = s_q.cycles;
        end
        apbReq.paddr >= `CSS_OFF_LIST: begin
          s_d.rsp.prdata[7:0] = stageMem[PW'(apbReq.paddr[7:2])];
        end
        default: s_d.rsp.prdata = 32'h0000_0000; // command, unmapped
      endcase
    end
    // register writes; the order of setup is software's business
    // setup registers
    if (wrEdge) begin
      if (apbReq.paddr == `CSS_OFF_CTRL) begin
        s_d.ctrl = apbReq.pwdata[8:0];
      end
      if (apbReq.paddr == `CSS_OFF_REPEAT) begin
        s_d.repeatCnt = apbReq.pwdata[15:0];
      end
      if (apbReq.paddr == `CSS_OFF_LEN && apbReq.pwdata[5:0] != 6'h00) begin
        s_d.len = apbReq.pwdata[5:0];
      end
    end
    // routing follows the control register at all times
    // backplane tree switches
    s_d.tree = 2'b00;
    if (s_q.ctrl[`CSS_CTRL_ROUTE]) begin
      s_d.tree[0] = 1'b1;
      s_d.tree[1] = (mode == CSS_TWO_WIRE_OHMS) || (mode == CSS_FOUR_WIRE_OHMS);
    end
    s_d.split = (mode == CSS_FOUR_WIRE_OHMS);
    // free-running countdown
    if (s_q.timer != 8'h00) begin
      s_d.timer = s_q.timer - 8'h01;
    end
    // sequencer
    unique case (s_q.st)
      CSS_IDLE, CSS_DONE: begin
        if (initiate || (s_q.st == CSS_IDLE && shot)) begin
          s_d.ptr = '0;
          s_d.memHeld = downloadable;
          s_d.cycles = s_q.repeatCnt;
          s_d.mask = 16'h0000;
          s_d.st = CSS_BREAK;
        end
      end
      CSS_BREAK: begin
        s_d.mask = 16'h0000;
        s_d.st = CSS_MAKE;
      end
      CSS_MAKE: begin
        s_d.mask = entryMask(curEntry, mode == CSS_FOUR_WIRE_OHMS);
        s_d.cpulse = 1'b1;
        s_d.tpulse = s_q.ctrl[`CSS_CTRL_TRIGOUT] & ~s_q.memHeld;
        s_d.timer = 8'(`CSS_FREE_CYCLES - 3);
        s_d.st = CSS_DWELL;
      end
      CSS_DWELL: begin
        if (advance) begin
          s_d.st = CSS_BREAK;
          s_d.mask = 16'h0000;
          if (!lastEntry) begin
            s_d.ptr = s_q.ptr + PW'(1);
          end else if (s_q.ctrl[`CSS_CTRL_ENDLESS]) begin
            s_d.ptr = '0;
          end else if (!s_q.memHeld && s_q.cycles > 16'h0001) begin
            s_d.ptr = '0;
            s_d.cycles = s_q.cycles - 16'h0001;
          end else begin
            s_d.mask = s_q.mask;
            s_d.cycles = 16'h0000;
            s_d.st = CSS_DONE;
          end
        end
      end
      default: s_d.st = CSS_IDLE; // unused codes recover
    endcase
    if (modeChange) begin
      s_d.mask = 16'h0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.repeatCnt <= `CSS_RST_REPEAT;
      s_q.len <= `CSS_RST_LEN;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign apbRsp = s_q.rsp;
  assign chanClose = s_q.mask;
  assign treeIsoClose = s_q.tree;
  assign bankSplit = s_q.split;
  assign closedPulse = s_q.cpulse;
  assign trigOut = s_q.tpulse;

  //////////////////////////////////////////////////////////////////////////
  // checks
  AST_ONE_PER_CARD: assert property (@(posedge clk) disable iff (reset)
    $countones(chanClose) <= ((mode == CSS_FOUR_WIRE_OHMS) ? 2 : 1))
    else $error("too many channels closed");

  AST_BREAK_FIRST: assert property (@(posedge clk) disable iff (reset)
    ($past(chanClose) != 16'h0000 && chanClose != 16'h0000) |-> chanClose == $past(chanClose))
    else $error("switch closed without opening the previous one");

  AST_PARTNER: assert property (@(posedge clk) disable iff (reset)
    (s_q.st == CSS_MAKE && mode == CSS_FOUR_WIRE_OHMS && curEntry[7:4] == CARD_ID)
    |=> chanClose[7:0] == chanClose[15:8] && $countones(chanClose) == 2)
    else $error("four-wire partner not closed");

  AST_TREE_TWO_WIRE: assert property (@(posedge clk) disable iff (reset)
    (s_q.ctrl[`CSS_CTRL_ROUTE] && mode == CSS_TWO_WIRE_OHMS) |=> treeIsoClose == 2'b11)
    else $error("tree switches not closed in two-wire backplane");

  AST_RESET_ISOLATED: assert property (@(posedge clk)
    $past(reset) |-> treeIsoClose == 2'b00 && chanClose == 16'h0000)
    else $error("route not isolated after reset");

  AST_WRAP: assert property (@(posedge clk) disable iff (reset)
    (advance && lastEntry && !s_q.memHeld && s_q.cycles > 16'h0001)
    |=> s_q.ptr == '0 && s_q.st == CSS_BREAK ##1 s_q.st == CSS_MAKE)
    else $error("pointer did not wrap to the first entry");

  AST_MEM_NO_REPEAT: assert property (@(posedge clk) disable iff (reset)
    (advance && lastEntry && s_q.memHeld && !s_q.ctrl[`CSS_CTRL_ENDLESS]) |=> s_q.st == CSS_DONE)
    else $error("memory-held list repeated without endless cycling");

  AST_ENDLESS: assert property (@(posedge clk) disable iff (reset)
    (advance && lastEntry && s_q.ctrl[`CSS_CTRL_ENDLESS]) |=> s_q.st == CSS_BREAK && s_q.ptr == '0)
    else $error("endless cycling stopped");

  AST_SPENT_HOLDS: assert property (@(posedge clk) disable iff (reset)
    (s_q.st == CSS_DONE && !initiate && !modeChange) |=> s_q.st == CSS_DONE && $stable(chanClose))
    else $error("spent scan moved without initiate");

  AST_MODE_OPENS: assert property (@(posedge clk) disable iff (reset)
    modeChange |=> chanClose == 16'h0000)
    else $error("switches left closed across a mode change");

  AST_HOST_STEP: assert property (@(posedge clk) disable iff (reset)
    (s_q.st == CSS_DWELL && src == CSS_HOST_COMMAND && shot && !lastEntry)
    |=> s_q.st == CSS_BREAK ##1 s_q.st == CSS_MAKE ##1 trigOut == s_q.ctrl[`CSS_CTRL_TRIGOUT])
    else $error("host trigger did not advance one channel");

  AST_FREE_RUN: assert property (@(posedge clk) disable iff (reset)
    (s_q.st == CSS_MAKE && src == CSS_FREE_RUNNING) |-> ##[1:200] s_q.st != CSS_DWELL)
    else $error("free-running scan stalled");

  AST_DOWNLOAD: assert property (@(posedge clk) disable iff (reset)
    (initiate && (src == CSS_HOST_COMMAND || s_q.ctrl[`CSS_CTRL_MIXED])) |=> !s_q.memHeld)
    else $error("list held locally for a host-stepped scan");
endmodule

/* sim/css_meter_model.sv */
// behavioural measuring instrument on the handshake lines of the sequencer
// assumes closedPulse is a one-cycle pulse in the core clock domain
`timescale 1ns/10ps
module css_meter_model (
  input wire logic clk, // core clock
  input wire logic reset, // synchronous, active high
  input wire logic closedPulse, // channel closed, start a reading
  input wire logic [3:0] settleDelay, // extra wait, 0 prompt, 15 slow
  output logic meterDone // reading complete, high four cycles
);
  logic [7:0] count_q; // cycles left in this reading
  logic busy_q; // a reading is in progress
  //////////////////////////////////////////////////////////////////////
  // one answer per closure; the line goes back low between readings,
  // so a stale high level can never count as a second completion
  always @(posedge clk) begin
    if (reset) begin
      busy_q <= 1'b0;
      count_q <= 8'h00;
      meterDone <= 1'b0;
    end else if (closedPulse) begin
      busy_q <= 1'b1;
      count_q <= {4'h0, settleDelay} + 8'h06;
      meterDone <= 1'b0;
    end else if (busy_q) begin
      count_q <= count_q - 8'h01;
      meterDone <= (count_q <= 8'h04) && (count_q != 8'h00);
      if (count_q == 8'h00) busy_q <= 1'b0;
    end
  end
endmodule

/* sim/tb_top.sv */
// self-checking bench of the channel scan sequencer: apb master and scans
// assumes css_pkg, css_defs.svh and the meter model are compiled first
`timescale 1ns/10ps
`include "css_defs.svh"
module tb_top
  import css_pkg::*;
;
  logic clk, reset, outsideEvent, meterDone, closedPulse, trigOut, bankSplit, err;
  cssApbReq_type req; // apb request driven here
  cssApbRsp_type rsp; // apb answer of the design
  logic [15:0] chanClose; // switch drive seen
  logic [1:0] treeIsoClose; // tree switches seen
  logic [3:0] meterDelay; // meter answer speed
  logic [31:0] lfsr, rd; // random state, read data
  logic [3:0] chans [0:31]; // channels of the current list
  int errCount, comparisons, closeCount, t, c, mi, k;
  int cyc = 0;
  css_scan_seq #(.LIST_DEPTH(32), .CARD_ID(4'h1)) dut_u (.clk(clk), .reset(reset), .apbReq(req), .apbRsp(rsp),
    .outsideEvent(outsideEvent), .meterDone(meterDone), .chanClose(chanClose), .treeIsoClose(treeIsoClose),
    .bankSplit(bankSplit), .closedPulse(closedPulse), .trigOut(trigOut));
  css_meter_model meter_u (.clk(clk), .reset(reset), .closedPulse(closedPulse), .settleDelay(meterDelay),
    .meterDone(meterDone));
  //////////////////////////////////////////////////////////////////////
  // clock, cycle count, closure count, hang limit
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (closedPulse === 1'b1) closeCount <= closeCount + 1;
    if (cyc > 40000) begin
      errCount++;
      finishTest();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task finishTest;
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one bit per closed channel, partner eight away in four-wire
  function logic [15:0] expMask(input logic [3:0] ch, input logic [1:0] m);
    logic [15:0] v;
    v = 16'h0001 << ch;
    if (m == CSS_FOUR_WIRE_OHMS) v = v | (16'h0001 << (ch ^ 4'h8));
    return v;
  endfunction
  function logic [1:0] expTree(input logic [1:0] m, input logic rt);
    if (!rt) return 2'h0;
    return (m == CSS_POTENTIAL_MEASURE) ? 2'h1 : 2'h3;
  endfunction
  //////////////////////////////////////////////////////////////////////
  // apb: setup, access held until pready is sampled, then release
  task apbXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    // no cycle budget here; only the bench hang limit ends a stuck wait
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  // wait for a closure, bounded well past the slowest advance
  task waitClose;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (closedPulse !== 1'b1 && n < 600);
  endtask
  task step(input int idx, input logic [1:0] m, input logic rt, input logic te);
    waitClose();
    check(32'(closedPulse), 32'h1);
    check(32'(chanClose), 32'(expMask(chans[idx], m)));
    check(32'(treeIsoClose), 32'(expTree(m, rt)));
    check(32'(trigOut), 32'(te));
    check(32'(bankSplit), 32'(m == CSS_FOUR_WIRE_OHMS));
  endtask
  // mode, route, source, list, then initiate
  task setup(input logic [1:0] m, input logic rt, input logic [2:0] s, input logic en, input logic mix,
             input int n, input logic [15:0] rep);
    int i;
    apbXfer(1'b1, `CSS_OFF_CTRL, {23'h0, mix, 1'b1, en, s, rt, m});
    apbXfer(1'b1, `CSS_OFF_REPEAT, {16'h0, rep});
    apbXfer(1'b1, `CSS_OFF_LEN, 32'(n));
    for (i = 0; i < n; i++) begin
      lfsr = nextRand(lfsr);
      chans[i] = lfsr[3:0];
      apbXfer(1'b1, `CSS_OFF_LIST + 8'(4 * i), {24'h0, 4'h1, chans[i]});
    end
    meterDelay <= lfsr[7:4];
    apbXfer(1'b1, `CSS_OFF_CMD, 32'h1);
  endtask
  task status(input logic [2:0] st, input logic mem);
    apbXfer(1'b0, `CSS_OFF_STATUS, 32'h0);
    check(32'(rd[`CSS_ST_STATE]), 32'(st));
    check(32'(rd[`CSS_ST_MEMHELD]), 32'(mem));
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    req = '0;
    outsideEvent = 1'b0;
    meterDelay = 4'h0;
    lfsr = 32'h00014AE6;
    errCount = 0;
    comparisons = 0;
    closeCount = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    check(32'(treeIsoClose), 32'h0);
    check(32'(chanClose), 32'h0);
    apbXfer(1'b0, `CSS_OFF_REPEAT, 32'h0);
    check(rd, 32'h1);
    apbXfer(1'b0, 8'h40, 32'h0);
    check(32'(err), 32'h1);
    // host stepped in every mode: two cycles of three, then spent
    for (mi = 0; mi < 3; mi++) begin
      setup(2'(mi), mi != 0, CSS_HOST_COMMAND, 1'b0, 1'b0, 3, 16'h0002);
      step(0, 2'(mi), mi != 0, 1'b1);
      for (k = 1; k < 7; k++) begin
        apbXfer(1'b1, `CSS_OFF_CMD, 32'h2);
        if (k < 6) begin
          @(posedge clk);
          #1;
          check(32'(chanClose), 32'h0);
          step(k % 3, 2'(mi), mi != 0, 1'b1);
        end
      end
      c = closeCount;
      apbXfer(1'b1, `CSS_OFF_CMD, 32'h2);
      repeat (20) @(posedge clk);
      #1;
      check(32'(closeCount - c), 32'h0);
      check(32'(chanClose), 32'(expMask(chans[2], 2'(mi))));
      status(3'h4, 1'b0);
    end
    // handshake advance: memory-held, repeat count of three ignored
    c = closeCount;
    setup(CSS_POTENTIAL_MEASURE, 1'b1, CSS_HANDSHAKE_LINE, 1'b0, 1'b0, 4, 16'h0003);
    for (k = 0; k < 4; k++) step(k, CSS_POTENTIAL_MEASURE, 1'b1, 1'b0);
    repeat (300) @(posedge clk);
    #1;
    check(32'(closeCount - c), 32'h4);
    status(3'h4, 1'b1);
    // endless cycling wraps, switching it off stops the scan
    setup(CSS_FOUR_WIRE_OHMS, 1'b1, CSS_HANDSHAKE_LINE, 1'b1, 1'b0, 2, 16'h0001);
    for (k = 0; k < 5; k++) step(k % 2, CSS_FOUR_WIRE_OHMS, 1'b1, 1'b0);
    apbXfer(1'b1, `CSS_OFF_CTRL, {23'h0, 1'b0, 1'b1, 1'b0, CSS_HANDSHAKE_LINE, 1'b1, CSS_FOUR_WIRE_OHMS});
    repeat (300) @(posedge clk);
    c = closeCount;
    repeat (300) @(posedge clk);
    #1;
    check(32'(closeCount - c), 32'h0);
    // free running steps on its own every 200 cycles
    setup(CSS_TWO_WIRE_OHMS, 1'b1, CSS_FREE_RUNNING, 1'b0, 1'b0, 3, 16'h0001);
    step(0, CSS_TWO_WIRE_OHMS, 1'b1, 1'b0);
    for (k = 1; k < 3; k++) begin
      t = cyc;
      step(k, CSS_TWO_WIRE_OHMS, 1'b1, 1'b0);
      check(32'(cyc - t), 32'(`CSS_FREE_CYCLES));
    end
    // let the last dwell run out so the next setup starts from a spent scan
    repeat (220) @(posedge clk);
    status(3'h4, 1'b1);
    // mixed group keeps the list under host control
    setup(CSS_POTENTIAL_MEASURE, 1'b1, CSS_HANDSHAKE_LINE, 1'b0, 1'b1, 1, 16'h0001);
    step(0, CSS_POTENTIAL_MEASURE, 1'b1, 1'b1);
    // the meter answer ends the one-entry scan well inside this wait
    repeat (60) @(posedge clk);
    status(3'h4, 1'b0);
    // outside event pin advances one channel
    setup(CSS_POTENTIAL_MEASURE, 1'b0, CSS_OUTSIDE_EVENT, 1'b0, 1'b0, 2, 16'h0001);
    step(0, CSS_POTENTIAL_MEASURE, 1'b0, 1'b1);
    @(posedge clk);
    outsideEvent <= 1'b1;
    repeat (4) @(posedge clk);
    outsideEvent <= 1'b0;
    step(1, CSS_POTENTIAL_MEASURE, 1'b0, 1'b1);
    finishTest();
  end
endmodule
